// file: hdl/xar_params.svh
// xar_params.svh: register offsets, reset values and field positions for onchip_ext_ram access routing
// assumes: included by the router and the testbench by bare name
`ifndef XAR_PARAMS_SVH
`define XAR_PARAMS_SVH
`define XAR_SYSCTL_OFS 8'hB1
`define XAR_PAGE_OFS 8'h01
`define XAR_PSEL_OFS 8'h02
`define XAR_DPL_OFS 8'h03
`define XAR_DPH_OFS 8'h04
`define XAR_STATUS_OFS 8'h05
`define XAR_SYSCTL_RESET 8'hA1
`define XAR_DIS_BIT 0
`define XAR_VIS_BIT 1
`define XAR_ONCHIP_EXT_RAM_LOW 16'hF700
`define XAR_RESET_NS 50
`define XAR_CLK_NS 25
`define XAR_RESET_CYC ((`XAR_RESET_NS + `XAR_CLK_NS - 1) / `XAR_CLK_NS)
`endif

// file: hdl/xar_pkg.sv
// xar_pkg: route and state types used by the routing block; the pointer memory does not use them
// assumes: nothing taken from xar_params.svh; state encodings defined here
package xar_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic bus_lo;
        logic bus_hi;
        logic strobes;
        logic use_onchip_ext_ram;
    } xar_route_t;
    typedef enum logic [2:0] {
        XAR_IDLE = 3'h1,
        XAR_ACCESS = 3'h2,
        XAR_DONE = 3'h4
    } xar_state_t;
endpackage

// file: hdl/xar_ptr_mem.sv
// xar_ptr_mem: bank of data pointers, one write port, one registered read
// assumes: single core_clk domain, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module xar_ptr_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rd_data;

    // read port
    always_comb
    begin
        next_rd_data = mem[rd_idx];
    end

    // storage and registered read; pointers clear at reset
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= '0;
            end
            rd_data <= '0;
        end
        else
        begin
            if (wr_en)
            begin
                mem[wr_idx] <= wr_data;
            end
            rd_data <= next_rd_data;
        end
    end
endmodule
`default_nettype wire

// file: hdl/xar_router.sv
// xar_router: routes each external move to on-chip onchip_ext_ram or the external bus
// assumes: cpu pulses move_req with stable kind; reset_n and ext_access_n are pins
// Behaviour
// [RULE1] after reset onchip_ext_ram access disabled; all moves go external
// [RULE2] disable bit zero sends in-range moves to on-chip onchip_ext_ram
// [RULE3] disable bit cannot be set again by software; only reset sets it
// [RULE4] visibility zero keeps strobes inactive on onchip_ext_ram accesses
// [RULE5] visibility one drives ports and pulses strobes on onchip_ext_ram accesses
// [RULE6] visibility ignored out of range or while onchip_ext_ram disabled
// [RULE7] pointer moves select onchip_ext_ram only at or above F700
// [RULE8] register-indirect moves take upper address from page register
// [RULE9] below-range moves always use external memory with active strobes
// [RULE10] pin high, bits zero, in range: ports i/o, strobes off, onchip_ext_ram
// [RULE11] pin low, bits zero, in range: ports bus, strobes off, onchip_ext_ram
// [RULE12] register-indirect moves keep upper port as i/o always
// [RULE13] system control resets to 1010XX01, undefined bits taken as zero
// [RULE14] reset pin held low at least two machine cycles by outside
// [RULE15] eight 16-bit pointers, one active, selected by pointer select
// [RULE16] page compare uses upper byte of onchip_ext_ram lower bound
`timescale 1ns/1ps
`default_nettype none
`include "xar_params.svh"
module xar_router #(
    parameter int NUM_PTR = 8,
    parameter int RESET_CYC = `XAR_RESET_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reset_n_pin,
    input wire logic ext_access_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic move_req,
    input wire logic move_is_ptr,
    input wire logic move_write,
    input wire logic [7:0] move_reg_addr,
    output logic [15:0] route_addr,
    output logic route_use_onchip_ext_ram,
    output logic port0_bus,
    output logic port2_bus,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    output logic route_valid,
    output logic sync_reset
);
    // elaboration check; reset counter is eight bits wide
    if (NUM_PTR != 8 || RESET_CYC < 1 || RESET_CYC > 254)
    begin : g_bad_params
        $error("xar_router: unsupported parameters");
    end

    localparam int PW = $clog2(NUM_PTR);

    // two-flop pin synchronisers; first stage read only by second
    logic [1:0] rst_sync;
    logic [1:0] ea_sync;
    logic [7:0] rst_cnt;
    logic [7:0] next_rst_cnt;
    logic next_sync_reset;
    logic int_reset;

    // [RULE14] pin reset held enough cycles
    always_comb
    begin
        next_rst_cnt = rst_cnt;
        next_sync_reset = sync_reset;
        if (!rst_sync[1])
        begin
            next_rst_cnt = (rst_cnt == 8'(RESET_CYC)) ? rst_cnt : rst_cnt + 8'h01;
            if (rst_cnt + 8'h01 >= 8'(RESET_CYC))
            begin
                next_sync_reset = 1'b1;
            end
        end
        else
        begin
            next_rst_cnt = 8'h00;
            next_sync_reset = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rst_sync <= 2'h3;
            ea_sync <= 2'h0;
            rst_cnt <= 8'h00;
            sync_reset <= 1'b0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], reset_n_pin};
            ea_sync <= {ea_sync[0], ext_access_n};
            rst_cnt <= next_rst_cnt;
            sync_reset <= next_sync_reset;
        end
    end

    assign int_reset = reset | sync_reset;

    // software registers
    logic [7:0] sysctl;
    logic [7:0] page;
    logic [PW-1:0] psel;
    logic [7:0] next_sysctl;
    logic [7:0] next_page;
    logic [PW-1:0] next_psel;
    logic [7:0] next_rdata;
    logic [15:0] ptr_rd;
    logic ptr_we;
    logic [15:0] ptr_wdata;
    logic [15:0] last_addr;
    logic last_onchip_ext_ram;

    // register write decode; byte writes to pointer patch one half
    always_comb
    begin
        next_sysctl = sysctl;
        next_page = page;
        next_psel = psel;
        ptr_we = 1'b0;
        ptr_wdata = ptr_rd;
        if (reg_wr)
        begin
            case (reg_addr)
                `XAR_SYSCTL_OFS:
                begin
                    next_sysctl = reg_wdata;
                    // [RULE3] disable bit sticks clear
                    next_sysctl[`XAR_DIS_BIT] = reg_wdata[`XAR_DIS_BIT] & sysctl[`XAR_DIS_BIT];
                end
                `XAR_PAGE_OFS: next_page = reg_wdata;
                // [RULE15] select active pointer
                `XAR_PSEL_OFS: next_psel = reg_wdata[PW-1:0];
                `XAR_DPL_OFS:
                begin
                    ptr_we = 1'b1;
                    ptr_wdata = {ptr_rd[15:8], reg_wdata};
                end
                `XAR_DPH_OFS:
                begin
                    ptr_we = 1'b1;
                    ptr_wdata = {reg_wdata, ptr_rd[7:0]};
                end
                default: next_sysctl = sysctl;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `XAR_SYSCTL_OFS: next_rdata = sysctl;
                `XAR_PAGE_OFS: next_rdata = page;
                `XAR_PSEL_OFS: next_rdata = 8'(psel);
                `XAR_DPL_OFS: next_rdata = ptr_rd[7:0];
                `XAR_DPH_OFS: next_rdata = ptr_rd[15:8];
                `XAR_STATUS_OFS: next_rdata = {6'h00, ea_sync[1], last_onchip_ext_ram};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // [RULE1] [RULE13] reset loads disable set
    always_ff @(posedge core_clk)
    begin
        if (int_reset)
        begin
            sysctl <= `XAR_SYSCTL_RESET;
            page <= 8'h00;
            psel <= '0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            sysctl <= next_sysctl;
            page <= next_page;
            psel <= next_psel;
            reg_rdata <= next_rdata;
        end
    end

    // pointer bank; read data registered, settles a cycle after select
    xar_ptr_mem #(.DEPTH(NUM_PTR), .WIDTH(16)) u_ptr (
        .core_clk(core_clk),
        .reset(int_reset),
        .wr_en(ptr_we),
        .wr_idx(psel),
        .wr_data(ptr_wdata),
        .rd_idx(psel),
        .rd_data(ptr_rd)
    );

    // routing decision, shared by pointer and page moves
    function automatic xar_pkg::xar_route_t xar_decide(input logic is_ptr, input logic [15:0] addr,
        input logic dis, input logic vis, input logic ea_hi);
        xar_pkg::xar_route_t r;
        logic in_rng;
        // [RULE7] [RULE16] same bound for pointer and page compare
        in_rng = is_ptr ? (addr >= `XAR_ONCHIP_EXT_RAM_LOW) : (addr[15:8] >= 8'(`XAR_ONCHIP_EXT_RAM_LOW >> 8));
        r.addr = addr;
        r.use_onchip_ext_ram = in_rng & ~dis;
        // [RULE9] external: bus and strobes active
        r.strobes = ~r.use_onchip_ext_ram | vis;
        // [RULE10] [RULE11] ea high with bits zero leaves ports as i/o
        r.bus_lo = ~r.use_onchip_ext_ram | vis | ~ea_hi;
        // [RULE12] upper port stays i/o for page moves
        r.bus_hi = is_ptr & r.bus_lo;
        return r;
    endfunction

    xar_pkg::xar_state_t state;
    xar_pkg::xar_state_t next_state;
    xar_pkg::xar_route_t cur;
    xar_pkg::xar_route_t next_cur;
    logic [15:0] eff_addr;
    logic [15:0] next_last_addr;
    logic next_last_onchip_ext_ram;

    // [RULE8] page register supplies upper address
    assign eff_addr = move_is_ptr ? ptr_rd : {page, move_reg_addr};

    // access sequencer: decide, access, release
    always_comb
    begin
        next_state = state;
        next_cur = cur;
        next_last_addr = last_addr;
        next_last_onchip_ext_ram = last_onchip_ext_ram;
        case (state)
            xar_pkg::XAR_IDLE:
            begin
                if (move_req)
                begin
                    // [RULE2] [RULE4] [RULE5] [RULE6] decision from control bits
                    next_cur = xar_decide(move_is_ptr, eff_addr, sysctl[`XAR_DIS_BIT],
                        sysctl[`XAR_VIS_BIT], ea_sync[1]);
                    next_last_addr = eff_addr;
                    next_last_onchip_ext_ram = next_cur.use_onchip_ext_ram;
                    next_state = xar_pkg::XAR_ACCESS;
                end
            end
            xar_pkg::XAR_ACCESS: next_state = xar_pkg::XAR_DONE;
            xar_pkg::XAR_DONE:
            begin
                next_cur = '0;
                next_state = xar_pkg::XAR_IDLE;
            end
            default: next_state = xar_pkg::XAR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (int_reset)
        begin
            state <= xar_pkg::XAR_IDLE;
            cur <= '0;
            last_addr <= 16'h0000;
            last_onchip_ext_ram <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cur <= next_cur;
            last_addr <= next_last_addr;
            last_onchip_ext_ram <= next_last_onchip_ext_ram;
        end
    end

    // outputs; strobes only during the access state
    logic strobe_on;
    assign strobe_on = (state == xar_pkg::XAR_ACCESS) & cur.strobes;
    assign rd_strobe_n = ~(strobe_on & ~move_write);
    assign wr_strobe_n = ~(strobe_on & move_write);
    assign route_addr = cur.addr;
    assign route_use_onchip_ext_ram = cur.use_onchip_ext_ram;
    assign port0_bus = cur.bus_lo & (state != xar_pkg::XAR_IDLE);
    assign port2_bus = cur.bus_hi & (state != xar_pkg::XAR_IDLE);
    assign route_valid = (state == xar_pkg::XAR_ACCESS);

    // [RULE3] disable bit never rises without reset
    chk_dis_sticky: assert property (@(posedge core_clk) disable iff (int_reset)
        !sysctl[0] |=> !sysctl[0]) else $error("disable bit set by software");
    // [RULE1] reset value loaded
    chk_reset_value: assert property (@(posedge core_clk)
        $fell(int_reset) |-> sysctl == 8'hA1) else $error("bad control reset value");
    // [RULE2] onchip_ext_ram chosen for in-range enabled move
    chk_onchip_ext_ram_pick: assert property (@(posedge core_clk) disable iff (int_reset)
        (state == xar_pkg::XAR_IDLE) && move_req && move_is_ptr && !sysctl[0] && eff_addr >= 16'hF700
        |=> route_use_onchip_ext_ram) else $error("onchip_ext_ram not selected");
    // [RULE9] below range goes external
    chk_below_ext: assert property (@(posedge core_clk) disable iff (int_reset)
        (state == xar_pkg::XAR_IDLE) && move_req && eff_addr[15:8] < 8'hF7
        |=> !route_use_onchip_ext_ram ##0 route_valid ##0 (!rd_strobe_n || !wr_strobe_n))
        else $error("below range not external");
    // [RULE4] no strobes on hidden onchip_ext_ram access
    chk_hidden_strobe: assert property (@(posedge core_clk) disable iff (int_reset)
        route_valid && route_use_onchip_ext_ram && !sysctl[1] |-> rd_strobe_n && wr_strobe_n)
        else $error("strobe on hidden onchip_ext_ram access");
    // [RULE5] visible onchip_ext_ram drives port
    chk_visible_bus: assert property (@(posedge core_clk) disable iff (int_reset)
        route_valid && route_use_onchip_ext_ram && sysctl[1] |-> port0_bus && !(rd_strobe_n && wr_strobe_n))
        else $error("visible access not on bus");
    // [RULE12] upper port i/o for page moves
    chk_page_hi_io: assert property (@(posedge core_clk) disable iff (int_reset)
        (state == xar_pkg::XAR_IDLE) && move_req && !move_is_ptr |=> !port2_bus ##1 !port2_bus)
        else $error("upper port driven on page move");
    // [RULE10] ea high, bits zero: ports i/o
    chk_ea_high_io: assert property (@(posedge core_clk) disable iff (int_reset)
        (state == xar_pkg::XAR_IDLE) && move_req && ea_sync[1] && sysctl[1:0] == 2'b00
        && eff_addr[15:8] >= 8'hF7 && (!move_is_ptr || eff_addr >= 16'hF700)
        |=> !port0_bus && rd_strobe_n && wr_strobe_n) else $error("ports not i/o");
    // [RULE11] ea low, bits zero: port bus, no strobes
    chk_ea_low_bus: assert property (@(posedge core_clk) disable iff (int_reset)
        (state == xar_pkg::XAR_IDLE) && move_req && !ea_sync[1] && sysctl[1:0] == 2'b00
        && eff_addr[15:8] >= 8'hF7 && (!move_is_ptr || eff_addr >= 16'hF700)
        |=> port0_bus && rd_strobe_n && wr_strobe_n) else $error("ports not bus");
    cov_onchip_ext_ram_hidden: cover property (@(posedge core_clk) route_valid && route_use_onchip_ext_ram && !sysctl[1]);
    cov_onchip_ext_ram_visible: cover property (@(posedge core_clk) route_valid && route_use_onchip_ext_ram && sysctl[1]);
    cov_external: cover property (@(posedge core_clk) route_valid && !route_use_onchip_ext_ram);
    cov_page_move: cover property (@(posedge core_clk) route_valid && !port2_bus && port0_bus);
endmodule
`default_nettype wire

// file: bench/xar_ext_mem.sv
// xar_ext_mem: external memory on the multiplexed bus, logs strobed cycles
// assumes: active-low strobes, decoded by the router from its access state and move_write
`timescale 1ns/1ps
`default_nettype none
module xar_ext_mem (
    input wire logic core_clk,
    input wire logic [15:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [7:0] hits,
    output logic [15:0] last
);
    initial hits = 8'h00;
    initial last = 16'h0000;
    // count every strobed cycle; contents not modelled, only visibility
    always @(posedge core_clk)
    begin
        if (!rd_n || !wr_n)
        begin
            hits <= hits + 8'h01;
            last <= addr;
        end
    end
endmodule
`default_nettype wire

// file: bench/xar_router_tb.sv
// xar_router_tb: routing checks through register port and move requests
// assumes: xar_params.svh on include path; external memory model alongside
`timescale 1ns/1ps
`default_nettype none
`include "xar_params.svh"
module xar_router_tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic rst_n = 1'b1;
    logic ea_n = 1'b1;
    logic [7:0] ra = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [7:0] mra = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic mreq = 1'b0;
    logic mptr = 1'b0;
    logic mw = 1'b0;
    logic [7:0] rdat;
    logic [15:0] radd;
    logic ux, p0, p2, rsn, wsn, vld, srst;
    logic [7:0] hits;
    logic [15:0] last;
    logic [7:0] v;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;

    xar_router dut (.core_clk(core_clk), .reset(reset), .reset_n_pin(rst_n), .ext_access_n(ea_n),
        .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
        .move_req(mreq), .move_is_ptr(mptr), .move_write(mw), .move_reg_addr(mra),
        .route_addr(radd), .route_use_onchip_ext_ram(ux), .port0_bus(p0), .port2_bus(p2),
        .rd_strobe_n(rsn), .wr_strobe_n(wsn), .route_valid(vld), .sync_reset(srst));
    xar_ext_mem mem (.core_clk(core_clk), .addr(radd), .rd_n(rsn), .wr_n(wsn), .hits(hits), .last(last));

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;
    // hang guard, well above the whole sequence
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            bad_count++;
            final_report();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdat;
    endtask

    task automatic wptr(input logic [7:0] i, input logic [15:0] val);
        wreg(`XAR_PSEL_OFS, i);
        wreg(`XAR_DPL_OFS, val[7:0]);
        wreg(`XAR_DPH_OFS, val[15:8]);
        @(posedge core_clk);
    endtask

    // ex = {onchip_ext_ram, strobe active, port0 bus, port2 bus}
    task automatic move(input logic ptr, input logic w, input logic [7:0] lo, input logic [15:0] ea,
        input logic [3:0] ex);
        logic [7:0] h0;
        int k;
        h0 = hits;
        @(posedge core_clk);
        mptr <= ptr;
        mw <= w;
        mra <= lo;
        mreq <= 1'b1;
        for (k = 0; k < 4 && vld !== 1'b1; k++)
        begin
            @(posedge core_clk);
            mreq <= 1'b0;
            #1;
        end
        chk("valid", 16'h0001, {15'h0000, vld});
        chk("addr", ea, radd);
        chk("onchip_ext_ram", {15'h0000, ex[3]}, {15'h0000, ux});
        chk("strobes", !ex[2] ? 16'h0003 : (w ? 16'h0002 : 16'h0001), {14'h0000, rsn, wsn});
        chk("port0", {15'h0000, ex[1]}, {15'h0000, p0});
        chk("port2", {15'h0000, ex[0]}, {15'h0000, p2});
        repeat (3) @(posedge core_clk);
        // one strobe cycle seen by the far side, none when hidden
        chk("ext hits", {8'h00, h0 + {7'h00, ex[2]}}, {8'h00, hits});
    endtask

    task automatic t_reset;
        rreg(`XAR_SYSCTL_OFS, v);
        chk("sysctl reset", 16'h00A1, {8'h00, v});
        wptr(8'h00, 16'hF800);
        move(1'b1, 1'b0, 8'h00, 16'hF800, 4'b0111);
        wreg(`XAR_SYSCTL_OFS, 8'hA3);
        move(1'b1, 1'b1, 8'h00, 16'hF800, 4'b0111);
    endtask

    task automatic t_ptrs;
        for (int i = 0; i < 8; i++)
            wptr(i[7:0], 16'h1011 * i[15:0]);
        for (int i = 7; i >= 0; i--)
        begin
            wreg(`XAR_PSEL_OFS, i[7:0]);
            @(posedge core_clk);
            move(1'b1, i[0], 8'h00, 16'h1011 * i[15:0], 4'b0111);
        end
    endtask

    task automatic t_lock;
        wreg(`XAR_SYSCTL_OFS, 8'hA0);
        rreg(`XAR_SYSCTL_OFS, v);
        chk("sysctl clear", 16'h00A0, {8'h00, v});
        wreg(`XAR_SYSCTL_OFS, 8'hA1);
        rreg(`XAR_SYSCTL_OFS, v);
        chk("sysctl relock", 16'h00A0, {8'h00, v});
    endtask

    task automatic t_table;
        wptr(8'h00, 16'hF6FF);
        move(1'b1, 1'b0, 8'h00, 16'hF6FF, 4'b0111);
        wptr(8'h00, 16'hF700);
        move(1'b1, 1'b1, 8'h00, 16'hF700, 4'b1000);
        wreg(`XAR_PAGE_OFS, 8'hF7);
        move(1'b0, 1'b0, 8'h12, 16'hF712, 4'b1000);
        wreg(`XAR_PAGE_OFS, 8'hF6);
        move(1'b0, 1'b1, 8'hFF, 16'hF6FF, 4'b0110);
        wreg(`XAR_SYSCTL_OFS, 8'hA2);
        wptr(8'h00, 16'hFFFF);
        move(1'b1, 1'b0, 8'h00, 16'hFFFF, 4'b1111);
        wreg(`XAR_PAGE_OFS, 8'hF7);
        move(1'b0, 1'b1, 8'h34, 16'hF734, 4'b1110);
        ea_n <= 1'b0;
        wreg(`XAR_SYSCTL_OFS, 8'hA0);
        repeat (4) @(posedge core_clk);
        move(1'b1, 1'b0, 8'h00, 16'hFFFF, 4'b1011);
        move(1'b0, 1'b1, 8'h56, 16'hF756, 4'b1010);
        // status: bit1 synced pin (low now), bit0 last move used onchip_ext_ram
        rreg(`XAR_STATUS_OFS, v);
        chk("status", 16'h0001, {8'h00, v});
    endtask

    task automatic t_pin;
        logic seen;
        seen = 1'b0;
        // pin held low twelve cycles, above two machine cycles
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (12)
        begin
            @(posedge core_clk);
            #1;
            if (srst === 1'b1)
                seen = 1'b1;
        end
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("pin reset seen", 16'h0001, {15'h0000, seen});
        rreg(`XAR_SYSCTL_OFS, v);
        chk("sysctl after pin", 16'h00A1, {8'h00, v});
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence after ten reset cycles
    initial
    begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_ptrs();
        t_lock();
        t_table();
        t_pin();
        final_report();
    end
endmodule
`default_nettype wire
